// file: hdl/rgc_map.vh
`ifndef RGC_MAP_VH
`define RGC_MAP_VH
// Contract
// [RQ1] gain choice zero selects automatic loop gain
// [RQ2] wait until strength exceeds threshold twice
// [RQ3] then pick best gain, leave waiting
// [RQ4] hold gain for packet, expose applied step
// [RQ5] packet mode, rearm off: keep previous gain
// [RQ6] rearm on: wait delay after fifo empty
// [RQ7] rearm command always restarts gain acquisition; code ignores it in ST_IDLE and receiver disable overrides it
// [RQ8] host keeps gain or restarts in continuous
// [RQ9] five ascending limits map level to steps
// [RQ10] reference: -174 + 7 + 8 + bw + 5
// [RQ11] host sets threshold to receiver sensitivity
// [RQ12] auto correction start-up uses correction filter width
// [RQ13] tracker adjusts digital gain every two bits
// [RQ14] tracker keeps adjusting while front gain frozen
// [RQ15] tracker works in every transfer mode
// [RQ16] host writes 0x20 or 0x30 to enable
// [RQ17] host should always enable tracker
// [RQ18] host selects gain during preamble in fsk
// [RQ19] host prefers constant ones in ook
// [RQ20] gain choice codes: auto, g1..g6, reserved
// [RQ21] measure command and done unusable with tracker

// gain choice field codes
`define RGC_CHOICE_AUTO     3'h0
`define RGC_CHOICE_G1       3'h1
`define RGC_CHOICE_G6       3'h6
`define RGC_CHOICE_RSVD     3'h7
// tracker test control enable values
`define RGC_TRK_LOW_INDEX   8'h20
`define RGC_TRK_NORMAL      8'h30
// reference level terms, dB
`define RGC_REF_FLOOR_DB    (-174)
`define RGC_REF_NF_DB       7
`define RGC_REF_DEMOD_DB    8
`define RGC_REF_FADE_DB     5
// consecutive samples above threshold
`define RGC_HITS_NEEDED     2'h2
`endif

// file: hdl/rgc_tracker.v
`include "rgc_map.vh"
module rgc_tracker #(
  parameter DW = 8  // sample width
) (
  // clock and reset
  input  wire          mclk_i,
  input  wire          resetn_i,
  // control
  input  wire          enable_i,
  input  wire          bit_tick_i,
  input  wire [DW-1:0] level_i,
  input  wire [DW-1:0] target_i,
  // result
  output reg  [DW-1:0] digital_gain_o
);
  // bit pair phase
  reg phase_reg;

  //////////////////////////////////////////////////////////////////////
  // adjust once every two bit ticks, regardless of front gain state
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg      <= 1'b0;
      digital_gain_o <= {DW{1'b0}};
    end else if (!enable_i) begin
      phase_reg      <= 1'b0;
    end else if (bit_tick_i) begin
      phase_reg <= ~phase_reg; // [RQ13]
      if (phase_reg) begin
        // step toward target; no mode gating [RQ14] [RQ15]
        if (level_i < target_i && digital_gain_o != {DW{1'b1}})
          digital_gain_o <= digital_gain_o + {{(DW-1){1'b0}}, 1'b1};
        else if (level_i > target_i && digital_gain_o != {DW{1'b0}})
          digital_gain_o <= digital_gain_o - {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: hdl/rgc_gain_control.v
`include "rgc_map.vh"
module rgc_gain_control #(
  parameter DW        = 8,  // strength sample width
  parameter DLY_W     = 16, // rearm delay counter width
  parameter BWLOG_DB  = 8   // 10log(2*bw) term, dB, supplied by config
) (
  // clock and reset
  input  wire             mclk_i,
  input  wire             resetn_i,
  // configuration
  input  wire [2:0]       front_gain_choice_i,
  input  wire             rx_enable_i,
  input  wire             packet_mode_i,
  input  wire             auto_listen_rearm_i,
  input  wire [DLY_W-1:0] rearm_wait_delay_i,
  input  wire             listen_rearm_cmd_i,
  input  wire             fifo_emptied_i,
  input  wire             afc_auto_i,
  input  wire [7:0]       channel_filter_width_i,
  input  wire [7:0]       correction_filter_width_i,
  input  wire [7:0]       tracker_test_control_i,
  // strength path
  input  wire             sample_valid_i,
  input  wire [DW-1:0]    signal_strength_sample_i,
  input  wire [DW-1:0]    strength_threshold_i,
  input  wire [DW-1:0]    gain_band_limit_first_i,
  input  wire [DW-1:0]    gain_band_limit_2_i,
  input  wire [DW-1:0]    gain_band_limit_3_i,
  input  wire [DW-1:0]    gain_band_limit_4_i,
  input  wire [DW-1:0]    gain_band_limit_fifth_i,
  input  wire             bit_tick_i,
  input  wire [DW-1:0]    digital_target_i,
  input  wire             strength_measure_cmd_i,
  // status
  output reg  [2:0]       applied_front_gain_o,
  output wire             waiting_o,
  output wire [7:0]       active_filter_width_o,
  output wire signed [9:0] gain_reference_dbm_o,
  output wire             strength_measure_usable_o,
  output reg              strength_measure_done_o,
  output wire [DW-1:0]    digital_gain_o
);
  //////////////////////////////////////////////////////////////////////
  // states
  localparam [1:0] ST_IDLE  = 2'h0; // receiver off
  localparam [1:0] ST_WAIT  = 2'h1; // waiting for strength
  localparam [1:0] ST_HOLD  = 2'h2; // gain frozen for packet
  localparam [1:0] ST_DELAY = 2'h3; // inter-packet rearm wait

  reg [1:0]       state_reg;   // current state
  reg [1:0]       state_next;  // next state
  reg [1:0]       hits_reg;    // consecutive samples above threshold
  reg [DLY_W-1:0] dly_reg;     // rearm delay countdown
  reg [2:0]       band_step;   // step picked from level
  wire            tracker_on;  // tracker enabled by test control
  wire            above;       // current sample above threshold

  assign tracker_on = (tracker_test_control_i == `RGC_TRK_LOW_INDEX) ||
                      (tracker_test_control_i == `RGC_TRK_NORMAL);
  assign above      = signal_strength_sample_i > strength_threshold_i;
  assign waiting_o  = (state_reg == ST_WAIT);

  //////////////////////////////////////////////////////////////////////
  // filter width used during correction and gain pick
  assign active_filter_width_o = (afc_auto_i &&
                                  (state_reg == ST_WAIT)) ?
                                 correction_filter_width_i :
                                 channel_filter_width_i; // [RQ12]

  // reference level in dBm
  // sum kept as a full word, then cut on purpose to the port width
  localparam integer REF_SUM  = `RGC_REF_FLOOR_DB + `RGC_REF_NF_DB +
                                `RGC_REF_DEMOD_DB + BWLOG_DB +
                                `RGC_REF_FADE_DB;
  localparam [31:0]  REF_WORD = REF_SUM;
  assign gain_reference_dbm_o = $signed(REF_WORD[9:0]); // [RQ10]

  //////////////////////////////////////////////////////////////////////
  // level to gain step, five ascending limits
  always @* begin
    if (signal_strength_sample_i < gain_band_limit_first_i)
      band_step = `RGC_CHOICE_G1; // [RQ9]
    else if (signal_strength_sample_i < gain_band_limit_2_i)
      band_step = 3'h2;
    else if (signal_strength_sample_i < gain_band_limit_3_i)
      band_step = 3'h3;
    else if (signal_strength_sample_i < gain_band_limit_4_i)
      band_step = 3'h4;
    else if (signal_strength_sample_i < gain_band_limit_fifth_i)
      band_step = 3'h5;
    else
      band_step = `RGC_CHOICE_G6;
  end

  //////////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rx_enable_i)
          state_next = ST_WAIT;
      end
      ST_WAIT: begin
        // second consecutive hit ends the wait [RQ2] [RQ3]
        if (sample_valid_i && above && hits_reg == 2'h1)
          state_next = ST_HOLD;
      end
      ST_HOLD: begin
        // rearm off keeps the gain for next packet [RQ5]
        if (packet_mode_i && auto_listen_rearm_i && fifo_emptied_i)
          state_next = ST_DELAY; // [RQ6]
      end
      ST_DELAY: begin
        if (dly_reg == {DLY_W{1'b0}})
          state_next = ST_WAIT; // [RQ6]
      end
      default: state_next = ST_IDLE;
    endcase
    // command restart wins in any active state; only receiver disable overrides it [RQ7]
    if (listen_rearm_cmd_i && state_reg != ST_IDLE)
      state_next = ST_WAIT;
    if (!rx_enable_i)
      state_next = ST_IDLE;
  end

  //////////////////////////////////////////////////////////////////////
  // state, hit count, delay and applied gain
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg            <= ST_IDLE;
      hits_reg             <= 2'h0;
      dly_reg              <= {DLY_W{1'b0}};
      applied_front_gain_o <= `RGC_CHOICE_G1;
    end else begin
      state_reg <= state_next;
      // count consecutive hits, any miss restarts
      if (state_next != ST_WAIT || state_reg != ST_WAIT)
        hits_reg <= 2'h0;
      else if (sample_valid_i)
        hits_reg <= above ? 2'h1 : 2'h0; // [RQ2]
      // load delay on entering the rearm wait
      if (state_next == ST_DELAY && state_reg != ST_DELAY)
        dly_reg <= rearm_wait_delay_i;
      else if (dly_reg != {DLY_W{1'b0}})
        dly_reg <= dly_reg - {{(DLY_W-1){1'b0}}, 1'b1};
      // manual choice applies directly; reserved code ignored
      if (front_gain_choice_i != `RGC_CHOICE_AUTO &&
          front_gain_choice_i != `RGC_CHOICE_RSVD)
        applied_front_gain_o <= front_gain_choice_i; // [RQ20]
      else if (front_gain_choice_i == `RGC_CHOICE_AUTO &&
               state_reg == ST_WAIT && state_next == ST_HOLD)
        applied_front_gain_o <= band_step; // [RQ1] [RQ3] [RQ4]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // manual strength measurement, disabled under the tracker
  assign strength_measure_usable_o = ~tracker_on; // [RQ21]

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i)
      strength_measure_done_o <= 1'b0;
    else if (tracker_on)
      strength_measure_done_o <= 1'b0; // [RQ21]
    else if (strength_measure_cmd_i)
      strength_measure_done_o <= 1'b0;
    else if (sample_valid_i)
      strength_measure_done_o <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // digital gain tracker after conversion
  rgc_tracker #(
    .DW (DW)
  ) u_tracker (
    .mclk_i         (mclk_i),
    .resetn_i       (resetn_i),
    .enable_i       (tracker_on),
    .bit_tick_i     (bit_tick_i),
    .level_i        (signal_strength_sample_i),
    .target_i       (digital_target_i),
    .digital_gain_o (digital_gain_o)
  );
endmodule

// file: verification/rgc_front_model.sv
// strength source: periodic samples and bit ticks
module rgc_front_model (
  input  wire       mclk_i,
  input  wire [7:0] level_i,
  output reg        sv_o   = 1'b0,
  output reg        tick_o = 1'b0,
  output reg  [7:0] smp_o  = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [2:0] cnt_reg = 3'h0;
  // a sample every 4 cycles, inverse level between samples
  always @(posedge mclk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    sv_o    <= cnt_reg[1:0] == 2'h3;
    tick_o  <= cnt_reg == 3'h7;
    smp_o   <= (cnt_reg[1:0] == 2'h3) ? level_i : ~level_i;
  end
endmodule

// file: verification/rgc_gain_control_assertions.sv
module rgc_checker #(parameter DW = 8) (
  input wire mclk_i, resetn_i, rx_enable_i, listen_rearm_cmd_i, afc_auto_i,
  input wire sample_valid_i, bit_tick_i, waiting_o, strength_measure_done_o,
  input wire strength_measure_usable_o,
  input wire [2:0] front_gain_choice_i, applied_front_gain_o,
  input wire [7:0] channel_filter_width_i, correction_filter_width_i,
  input wire [7:0] tracker_test_control_i, active_filter_width_o,
  input wire [DW-1:0] signal_strength_sample_i, strength_threshold_i,
  input wire [DW-1:0] digital_gain_o,
  input wire signed [9:0] gain_reference_dbm_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire trk_on = tracker_test_control_i == 8'h20 ||
                tracker_test_control_i == 8'h30;
  ref_level_a: assert property (gain_reference_dbm_o == 10'sh36e)
    else $error("reference level wrong");
  gain_hold_a: assert property (front_gain_choice_i == 3'h0 && !waiting_o
    && $past(!waiting_o) && $past(front_gain_choice_i) == 3'h0
    |-> $stable(applied_front_gain_o)) else $error("held gain moved");
  manual_gain_a: assert property (front_gain_choice_i inside {[1:6]}
    |=> applied_front_gain_o == $past(front_gain_choice_i))
    else $error("manual gain not applied");
  rearm_cmd_a: assert property (rx_enable_i && listen_rearm_cmd_i
    ##1 rx_enable_i |-> ##[0:1] waiting_o) else $error("rearm ignored");
  filter_sel_a: assert property (active_filter_width_o ==
    ((waiting_o && afc_auto_i) ? correction_filter_width_i
    : channel_filter_width_i)) else $error("wrong filter width");
  measure_off_a: assert property (trk_on |-> !strength_measure_usable_o
    ##1 (!trk_on || !strength_measure_done_o)) else $error("measure usable");
  dgain_tick_a: assert property ($changed(digital_gain_o)
    |-> $past(bit_tick_i) && $past(trk_on)) else $error("untimed dgain");
  leave_wait_a: assert property ($fell(waiting_o) && rx_enable_i
    |-> $past(sample_valid_i) && $past(signal_strength_sample_i >
    strength_threshold_i)) else $error("left wait without hit");
  leave_c: cover property ($fell(waiting_o));
  rearm_c: cover property (listen_rearm_cmd_i && rx_enable_i);
  tick_c: cover property ($changed(digital_gain_o));
endmodule
bind rgc_gain_control rgc_checker #(.DW(DW)) chk_u (.*);

// file: verification/receiver_gain_control_bench.sv
module receiver_gain_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  reg mclk_i = 1'b0, resetn_i = 1'b0, rx = 1'b0, cmd = 1'b0, fifo = 1'b0;
  reg arm = 1'b0, afc = 1'b0, mcmd = 1'b0, pkt = 1'b1;
  reg [2:0] choice = 3'h0;
  reg [7:0] trk = 8'h00, lvl = 8'h10, thr = 8'h14, tgt = 8'hff;
  reg [7:0] l1 = 8'h28, l2 = 8'h3c, l3 = 8'h50, l4 = 8'h64, l5 = 8'h78;
  wire sv, tick, wt, use_o, done;
  wire [2:0] gain;
  wire [7:0] smp, fw, dg;
  wire signed [9:0] ref_o;
  integer n_errors = 0, checks = 0, i, k;
  always #12.5 mclk_i = ~mclk_i;
  rgc_front_model fm_u (.mclk_i(mclk_i), .level_i(lvl), .sv_o(sv),
    .tick_o(tick), .smp_o(smp));
  rgc_gain_control dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .front_gain_choice_i(choice), .rx_enable_i(rx), .packet_mode_i(pkt),
    .auto_listen_rearm_i(arm), .rearm_wait_delay_i(16'h0005),
    .listen_rearm_cmd_i(cmd), .fifo_emptied_i(fifo), .afc_auto_i(afc),
    .channel_filter_width_i(8'h11), .correction_filter_width_i(8'h22),
    .tracker_test_control_i(trk), .sample_valid_i(sv),
    .signal_strength_sample_i(smp), .strength_threshold_i(thr),
    .gain_band_limit_first_i(l1), .gain_band_limit_2_i(l2),
    .gain_band_limit_3_i(l3), .gain_band_limit_4_i(l4),
    .gain_band_limit_fifth_i(l5), .bit_tick_i(tick), .digital_target_i(tgt),
    .strength_measure_cmd_i(mcmd), .applied_front_gain_o(gain),
    .waiting_o(wt), .active_filter_width_o(fw), .gain_reference_dbm_o(ref_o),
    .strength_measure_usable_o(use_o), .strength_measure_done_o(done),
    .digital_gain_o(dg));
  // compare one value
  task chk(input [9:0] got, input [9:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // wait a bounded time for the waiting flag
  task wait_wt(input v, input integer n);
    begin
      i = 0;
      while (wt !== v && i < n) begin
        @(negedge mclk_i);
        i = i + 1;
      end
      chk(wt, v);
    end
  endtask
  // restart, hold below threshold, then acquire at a level
  task acq(input [7:0] l, input [2:0] g);
    begin
      @(posedge mclk_i) cmd <= 1'b1;
      lvl <= 8'h10;
      @(posedge mclk_i) cmd <= 1'b0;
      wait_wt(1'b1, 3);
      repeat (16) @(negedge mclk_i);
      chk(wt, 1'b1);
      @(posedge mclk_i) lvl <= l;
      wait_wt(1'b0, 16);
      chk(gain, g);
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d of %0d checks", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    chk(gain, 10'h001);
    chk(dg, 10'h000);
    chk(ref_o, 10'h36e);
    @(posedge mclk_i) rx <= 1'b1;
    for (k = 0; k < 6; k = k + 1)
      acq(8'h1e + k[7:0] * 8'h14, k[2:0] + 3'h1);
    $display("acquisition test done");
    @(posedge mclk_i) lvl <= 8'h1e;
    fifo <= 1'b1;
    @(posedge mclk_i) fifo <= 1'b0;
    repeat (20) @(negedge mclk_i);
    chk(wt, 1'b0);
    chk(gain, 10'h006);
    @(posedge mclk_i) arm <= 1'b1;
    lvl <= 8'h10;
    afc <= 1'b1;
    fifo <= 1'b1;
    @(posedge mclk_i) fifo <= 1'b0;
    @(negedge mclk_i);
    chk(wt, 1'b0);
    wait_wt(1'b1, 10);
    chk(fw, 10'h022);
    @(posedge mclk_i) lvl <= 8'h46;
    wait_wt(1'b0, 16);
    chk(fw, 10'h011);
    $display("rearm test done");
    // continuous transfer: fifo emptying does not rearm, command does
    @(posedge mclk_i) pkt <= 1'b0;
    fifo <= 1'b1;
    @(posedge mclk_i) fifo <= 1'b0;
    repeat (12) @(negedge mclk_i);
    chk(wt, 1'b0);
    acq(8'h82, 3'h6);
    $display("continuous test done");
    for (k = 1; k < 8; k = k + 1) begin
      @(posedge mclk_i) choice <= k[2:0];
      repeat (2) @(negedge mclk_i);
      chk(gain, (k == 7) ? 10'h006 : k[9:0]);
    end
    $display("manual test done");
    chk(done, 1'b1);
    @(posedge mclk_i) trk <= 8'h30;
    choice <= 3'h0;
    mcmd <= 1'b1;
    @(posedge mclk_i) mcmd <= 1'b0;
    repeat (40) @(negedge mclk_i);
    chk(use_o, 1'b0);
    chk(done, 1'b0);
    chk(dg == 8'h00, 1'b0);
    @(posedge mclk_i) trk <= 8'h20;
    @(negedge mclk_i);
    chk(use_o, 1'b0);
    $display("tracker test done");
    finish_test;
  end
endmodule
